// *** afm_defines.vh ***
// Purpose : Constants for the converter fault flag and trigger block
// Assumes : Byte addresses on a 32-bit Avalon-MM slave
// Notes   : Include by bare name
`ifndef AFM_DEFINES_VH
`define AFM_DEFINES_VH
// ======================================================================
// Register byte offsets
`define AFM_OFS_STATUS   6'h00
`define AFM_OFS_IFCFG    6'h04
`define AFM_OFS_IOCFG    6'h08
`define AFM_OFS_CHEN     6'h0C
`define AFM_OFS_SETUP0   6'h10
`define AFM_OFS_SETUP1   6'h14
`define AFM_OFS_RESULT   6'h18
`define AFM_OFS_CHKSUM   6'h1C
// ======================================================================
// Interface configuration fields
`define AFM_IF_ALT       0
`define AFM_IF_APPEND    1
`define AFM_IF_MON       2
// ======================================================================
// Io configuration fields
`define AFM_IO_MODE_LO   0
`define AFM_IO_MODE_HI   1
`define AFM_IO_PDATA     2
// ======================================================================
// Fault pin modes
`define AFM_FP_OFF       2'h0
`define AFM_FP_INPUT     2'h1
`define AFM_FP_ODRAIN    2'h2
`define AFM_FP_GPO       2'h3
// ======================================================================
// Reset values
`define AFM_RST_IFCFG    3'h0
`define AFM_RST_IOCFG    3'h0
`define AFM_RST_CHEN     16'h0001
`define AFM_RST_SETUP    16'h0000
// ======================================================================
// Sequencer states
`define AFM_ST_IDLE      2'h0
`define AFM_ST_CONV      2'h1
`define AFM_ST_HOLD      2'h2
`endif

// *** afm_fault_trigger.v ***
// Purpose : Fault flags, register monitor, fault pin and trigger sequencer
// Assumes : One 25 MHz clock, synchronous pins, Avalon-MM register access
// Notes   : Summary of operation follows
//
// Summary of operation
// - Writing the alternate trigger bit to 1 enters alternate trigger mode.
// - Trigger low: finish conversion, advance channel, wait for trigger high to start.
// - Done output goes low when conversion ends and result holds new value.
// - Trigger low never aborts the running conversion, only delays the next start.
// - Status holds three fault flags: conversion, write checksum, register change.
// - Overrange or underrange conversion sets the conversion fault flag.
// - Undervoltage gives an all-zero result, overvoltage an all-ones result.
// - Conversion fault clears only when condition is gone, not on result read.
// - Write checksum mismatch sets the write checksum fault flag.
// - An explicit status register read clears the write checksum fault flag.
// - With monitor enabled, any change of monitored registers sets register fault.
// - Writing monitor enable to 0 clears a pending register fault.
// - Result, status and interface configuration are not monitored.
// - Mode 10: pin is open-drain, low while any fault flag is set.
// - Mode 01: pin is active-low input ORed into conversion fault flag.
// - In input mode the pin level shows in the fault pin data bit.
// - Mode 00 disables the pin; mode 11 drives fault pin data.
// - With status append set, status follows every shifted-out result.
// - The low four status bits carry the channel of the conversion.
`timescale 1ns/1ps
`include "afm_defines.vh"

module afm_fault_trigger #(
  parameter NCH = 16,
  parameter RW  = 24
) (
  input  wire          ref_clk_in,
  input  wire          resetn_in,
  input  wire [5:0]    avs_address_in,
  input  wire          avs_read_in,
  input  wire          avs_write_in,
  input  wire [31:0]   avs_writedata_in,
  output reg  [31:0]   avs_readdata_out,
  output reg           avs_waitrequest_out,
  input  wire          trigger_n_in,
  input  wire          conv_done_in,
  input  wire [RW-1:0] conv_result_in,
  input  wire          overrange_in,
  input  wire          underrange_in,
  input  wire          crc_bad_in,
  input  wire          fault_pin_in,
  output reg           fault_pin_out,
  output reg           fault_pin_oe_out,
  output reg           conv_start_out,
  output reg  [3:0]    channel_out,
  output reg           conv_done_n_out,
  output reg  [RW+7:0] data_word_out,
  output reg           data_status_out,
  output reg           data_valid_out
);

  // ====================================================================
  // Registers and signals
  reg  [2:0]    ifcfg_q;
  reg  [2:0]    iocfg_q;
  reg  [15:0]   chen_q;
  reg  [15:0]   setup0_q;
  reg  [15:0]   setup1_q;
  reg  [RW-1:0] result_q;
  reg           adc_err_q;
  reg           crc_err_q;
  reg           reg_err_q;
  reg  [15:0]   chk_ref_q;
  reg           trig_q;
  reg           trig_prev_q;
  reg           trig_low_q;
  reg           fpin_q;
  reg  [1:0]    state_q;
  reg  [3:0]    chan_q;
  reg           acc_q;
  wire          req;
  wire          take;
  wire          wr;
  wire          rd;
  wire [1:0]    fp_mode;
  wire          ext_fault;
  wire          adc_err;
  wire          any_err;
  wire [7:0]    status;
  wire [15:0]   chk_now;
  wire [3:0]    chan_next;
  wire          cond_bad;
  wire [RW-1:0] res_d;

  assign req       = avs_read_in | avs_write_in;
  assign take      = req & acc_q;
  assign wr        = take & avs_write_in;
  assign rd        = take & avs_read_in;
  assign fp_mode   = iocfg_q[`AFM_IO_MODE_HI:`AFM_IO_MODE_LO];
  assign ext_fault = (fp_mode == `AFM_FP_INPUT) & ~fpin_q;
  assign adc_err   = adc_err_q | ext_fault;
  assign any_err   = adc_err | crc_err_q | reg_err_q;
  assign status    = {conv_done_n_out, adc_err, crc_err_q, reg_err_q, chan_q};
  assign chk_now   = chen_q ^ setup0_q ^ setup1_q ^ {13'h0000, iocfg_q};
  assign cond_bad  = overrange_in | underrange_in;
  assign res_d     = overrange_in ? {RW{1'b1}} :
                     underrange_in ? {RW{1'b0}} : conv_result_in;

  // ====================================================================
  // Next enabled channel after the current one, wrapping round
  function [3:0] next_chan;
    input [3:0]  cur;
    input [15:0] en;
    integer      i;
    reg   [3:0]  c;
    reg          hit;
    begin
      next_chan = cur;
      hit = 1'b0;
      for (i = 1; i <= NCH; i = i + 1)
      begin
        c = cur + i[3:0];
        if (!hit && en[c])
        begin
          next_chan = c;
          hit = 1'b1;
        end
      end
    end
  endfunction

  assign chan_next = next_chan(chan_q, chen_q);

  // ====================================================================
  // Avalon-MM slave: one wait cycle, data ready at the accepting edge
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      avs_waitrequest_out <= 1'b1;
      acc_q               <= 1'b0;
      avs_readdata_out    <= 32'h00000000;
    end
    else
    begin
      acc_q               <= req & ~acc_q;
      avs_waitrequest_out <= ~(req & ~acc_q);
      if (avs_read_in & ~acc_q)
      begin
        case (avs_address_in)
          `AFM_OFS_STATUS: avs_readdata_out <= {24'h000000, status};
          `AFM_OFS_IFCFG:  avs_readdata_out <= {29'h00000000, ifcfg_q};
          `AFM_OFS_IOCFG:  avs_readdata_out <= {29'h00000000,
                             (fp_mode == `AFM_FP_INPUT) ? fpin_q : iocfg_q[`AFM_IO_PDATA],
                             fp_mode};
          `AFM_OFS_CHEN:   avs_readdata_out <= {16'h0000, chen_q};
          `AFM_OFS_SETUP0: avs_readdata_out <= {16'h0000, setup0_q};
          `AFM_OFS_SETUP1: avs_readdata_out <= {16'h0000, setup1_q};
          `AFM_OFS_RESULT: avs_readdata_out <= {{(32-RW){1'b0}}, result_q};
          `AFM_OFS_CHKSUM: avs_readdata_out <= {16'h0000, chk_ref_q};
          default:         avs_readdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // ====================================================================
  // Configuration registers
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ifcfg_q  <= `AFM_RST_IFCFG;
      iocfg_q  <= `AFM_RST_IOCFG;
      chen_q   <= `AFM_RST_CHEN;
      setup0_q <= `AFM_RST_SETUP;
      setup1_q <= `AFM_RST_SETUP;
    end
    else if (wr)
    begin
      case (avs_address_in)
        `AFM_OFS_IFCFG:  ifcfg_q  <= avs_writedata_in[2:0];
        `AFM_OFS_IOCFG:  iocfg_q  <= avs_writedata_in[2:0];
        `AFM_OFS_CHEN:   chen_q   <= avs_writedata_in[15:0];
        `AFM_OFS_SETUP0: setup0_q <= avs_writedata_in[15:0];
        `AFM_OFS_SETUP1: setup1_q <= avs_writedata_in[15:0];
        default:         ifcfg_q  <= ifcfg_q;
      endcase
    end
  end

  // ====================================================================
  // Pin sampling
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      trig_q      <= 1'b1;
      trig_prev_q <= 1'b1;
      fpin_q      <= 1'b1;
    end
    else
    begin
      trig_q      <= trigger_n_in;
      trig_prev_q <= trig_q;
      fpin_q      <= fault_pin_in;
    end
  end

  // ====================================================================
  // Fault flags, set wins over clear
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      adc_err_q <= 1'b0;
      crc_err_q <= 1'b0;
      reg_err_q <= 1'b0;
      chk_ref_q <= 16'h0000;
    end
    else
    begin
      if (conv_done_in & cond_bad)
        adc_err_q <= 1'b1;
      else if (!cond_bad)
        adc_err_q <= 1'b0;
      if (crc_bad_in)
        crc_err_q <= 1'b1;
      else if (rd && avs_address_in == `AFM_OFS_STATUS)
        crc_err_q <= 1'b0;
      if (!ifcfg_q[`AFM_IF_MON])
        chk_ref_q <= chk_now;
      if (ifcfg_q[`AFM_IF_MON] && chk_now != chk_ref_q)
        reg_err_q <= 1'b1;
      else if (!ifcfg_q[`AFM_IF_MON])
        reg_err_q <= 1'b0;
    end
  end

  // ====================================================================
  // Fault pin driver
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      fault_pin_out    <= 1'b1;
      fault_pin_oe_out <= 1'b0;
    end
    else
    begin
      case (fp_mode)
        `AFM_FP_ODRAIN:
        begin
          fault_pin_out    <= 1'b0;
          fault_pin_oe_out <= any_err;
        end
        `AFM_FP_GPO:
        begin
          fault_pin_out    <= iocfg_q[`AFM_IO_PDATA];
          fault_pin_oe_out <= 1'b1;
        end
        default:
        begin
          fault_pin_out    <= 1'b1;
          fault_pin_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // ====================================================================
  // Channel sequencer with alternate trigger
  always @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q         <= `AFM_ST_IDLE;
      chan_q          <= 4'hF;
      trig_low_q      <= 1'b0;
      conv_start_out  <= 1'b0;
      channel_out     <= 4'h0;
      conv_done_n_out <= 1'b1;
      result_q        <= {RW{1'b0}};
      data_word_out   <= {(RW+8){1'b0}};
      data_status_out <= 1'b0;
      data_valid_out  <= 1'b0;
    end
    else
    begin
      conv_start_out <= 1'b0;
      data_valid_out <= 1'b0;
      if (rd && avs_address_in == `AFM_OFS_RESULT)
        conv_done_n_out <= 1'b1;
      if (trig_prev_q & ~trig_q)
        trig_low_q <= 1'b1;
      case (state_q)
        `AFM_ST_IDLE:
        begin
          if (chen_q != 16'h0000 && (!ifcfg_q[`AFM_IF_ALT] || trig_q))
          begin
            chan_q         <= chan_next;
            channel_out    <= chan_next;
            conv_start_out <= 1'b1;
            trig_low_q     <= 1'b0;
            state_q        <= `AFM_ST_CONV;
          end
        end
        `AFM_ST_CONV:
        begin
          if (conv_done_in)
          begin
            result_q        <= res_d;
            conv_done_n_out <= 1'b0;
            data_word_out   <= {res_d, ifcfg_q[`AFM_IF_APPEND] ?
                                {conv_done_n_out & 1'b0, adc_err | cond_bad,
                                 crc_err_q, reg_err_q, chan_q} : 8'h00};
            data_status_out <= ifcfg_q[`AFM_IF_APPEND];
            data_valid_out  <= 1'b1;
            chan_q          <= chan_next;
            channel_out     <= chan_next;
            trig_low_q      <= 1'b0;
            if (chen_q == 16'h0000)
              state_q <= `AFM_ST_IDLE;
            else if (ifcfg_q[`AFM_IF_ALT] && (trig_low_q || !trig_q))
              state_q <= `AFM_ST_HOLD;
            else
              conv_start_out <= 1'b1;
          end
        end
        `AFM_ST_HOLD:
        begin
          if (trig_q)
          begin
            conv_start_out <= 1'b1;
            trig_low_q     <= 1'b0;
            state_q        <= `AFM_ST_CONV;
          end
        end
        default:
          state_q <= `AFM_ST_IDLE;
      endcase
    end
  end

endmodule // afm_fault_trigger

// *** afm_conv_model.sv ***
// Purpose: Converter core model that answers each start with one result
// Assumes: Starts are single-cycle pulses
// Notes: Delay is 3 cycles when prompt, 12 when slow
`timescale 1ns/1ps
module afm_conv_model #(
  parameter RW = 24
) (
  input  wire          ref_clk_in,
  input  wire          conv_start_in,
  input  wire          slow_in,
  input  wire          over_in,
  input  wire          under_in,
  output reg           conv_done_out,
  output reg  [RW-1:0] conv_result_out
);
  // ======================================================================
  // Conversion timing
  integer cnt_q = 0;
  initial conv_done_out = 1'b0;
  initial conv_result_out = {RW{1'b0}};
  always @(posedge ref_clk_in)
  begin
    conv_done_out <= 1'b0;
    conv_result_out <= ~conv_result_out;
    if (conv_start_in)
      cnt_q <= slow_in ? 12 : 3;
    else if (cnt_q > 0)
    begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == 1)
      begin
        conv_done_out <= 1'b1;
        conv_result_out <= under_in ? {RW{1'b0}} : over_in ? {RW{1'b1}} : {RW/4{4'hA}};
      end
    end
  end
endmodule // afm_conv_model

// *** afm_fault_trigger_asserts.sv ***
// Purpose: Port assertions for the fault flag and trigger block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every instance
`timescale 1ns/1ps
`include "afm_defines.vh"
module afm_ft_asserts #(
  parameter RW = 24
) (
  input wire          ref_clk_in,
  input wire          resetn_in,
  input wire [5:0]    avs_address_in,
  input wire          avs_read_in,
  input wire          avs_write_in,
  input wire          avs_waitrequest_out,
  input wire          trigger_n_in,
  input wire          conv_done_in,
  input wire [RW-1:0] conv_result_in,
  input wire          overrange_in,
  input wire          underrange_in,
  input wire          conv_start_out,
  input wire [3:0]    channel_out,
  input wire          conv_done_n_out,
  input wire [RW+7:0] data_word_out,
  input wire          data_status_out,
  input wire          data_valid_out
);
  // ======================================================================
  // Checks
  default clocking dclk @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  a_wait_cause: assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
    else $error("waitrequest fell without request");
  a_valid_pulse: assert property (data_valid_out |=> !data_valid_out)
    else $error("data valid longer than one cycle");
  a_valid_cause: assert property (data_valid_out |-> $past(conv_done_in))
    else $error("data valid without finished conversion");
  a_done_low: assert property (data_valid_out |-> !conv_done_n_out)
    else $error("done output not low with new result");
  a_result_pass: assert property (data_valid_out |->
    data_word_out[RW+7:8] == ($past(overrange_in) ? {RW{1'b1}} :
                              $past(underrange_in) ? {RW{1'b0}} : $past(conv_result_in)))
    else $error("result field differs from converter result");
  a_chan_tag: assert property (data_valid_out && data_status_out |-> data_word_out[3:0] == $past(channel_out))
    else $error("status channel differs from converted channel");
  a_start_trig: assert property (conv_start_out |-> $past(trigger_n_in))
    else $error("conversion started while trigger low");
  a_done_release: assert property ($rose(conv_done_n_out) |->
    $past(avs_read_in && !avs_waitrequest_out && avs_address_in == `AFM_OFS_RESULT))
    else $error("done output released without result read");
  c_status: cover property (data_valid_out && data_status_out);
  c_start: cover property (conv_start_out);
  c_release: cover property ($rose(conv_done_n_out));
endmodule // afm_ft_asserts
bind afm_fault_trigger afm_ft_asserts #(.RW(RW)) u_ft_asserts (.ref_clk_in, .resetn_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_waitrequest_out, .trigger_n_in, .conv_done_in, .conv_result_in,
  .overrange_in, .underrange_in,
  .conv_start_out, .channel_out, .conv_done_n_out, .data_word_out, .data_status_out, .data_valid_out);

// *** afm_fault_trigger_tb.sv ***
// Purpose: Self-checking bench for the fault flag and trigger block
// Assumes: Converter core model on the far side
// Notes: Register access through Avalon-MM tasks
`timescale 1ns/1ps
`include "afm_defines.vh"
module afm_fault_trigger_tb;
  reg         ref_clk_in = 1'b0;
  reg         resetn_in = 1'b0;
  reg  [5:0]  adr = 6'h00;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wd = 32'h0;
  reg         trig_n = 1'b1;
  reg         over = 1'b0;
  reg         under = 1'b0;
  reg         crc_bad = 1'b0;
  reg         ext_lvl = 1'b1;
  reg         slow = 1'b0;
  reg  [31:0] vword;
  reg         vstat;
  reg  [31:0] junk;
  reg  [3:0]  cv;
  integer     miscompares = 0;
  integer     compares = 0;
  integer     hits;
  wire [31:0] rdata;
  wire [31:0] word;
  wire [23:0] res;
  wire [3:0]  chan;
  wire        wreq, done, fp_out, fp_oe, start, done_n, dstat, dvalid;
  wire        pin = fp_oe ? fp_out : ext_lvl;
  always #20 ref_clk_in = ~ref_clk_in;
  afm_fault_trigger uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .trigger_n_in(trig_n), .conv_done_in(done), .conv_result_in(res),
    .overrange_in(over), .underrange_in(under), .crc_bad_in(crc_bad), .fault_pin_in(pin),
    .fault_pin_out(fp_out), .fault_pin_oe_out(fp_oe), .conv_start_out(start), .channel_out(chan),
    .conv_done_n_out(done_n), .data_word_out(word), .data_status_out(dstat), .data_valid_out(dvalid));
  afm_conv_model core (.ref_clk_in(ref_clk_in), .conv_start_in(start), .slow_in(slow), .over_in(over),
    .under_in(under), .conv_done_out(done), .conv_result_out(res));
  // ======================================================================
  // Tasks
  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task bus(input w, input [5:0] a, input [31:0] d, output [31:0] q);
    integer n;
  begin
    n = 0;
    @(posedge ref_clk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge ref_clk_in);
    while (wreq !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk_in);
      n = n + 1;
    end
    if (n >= 50)
      miscompares = miscompares + 1;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  end
  endtask
  task wrr(input [5:0] a, input [31:0] d);
    bus(1'b1, a, d, junk);
  endtask
  task rdc(input [5:0] a, input [31:0] m, input [31:0] e);
  begin
    bus(1'b0, a, 32'h0, junk);
    chk(junk & m, e);
  end
  endtask
  task wait_ev(input sel);
    integer n;
  begin
    n = 0;
    @(posedge ref_clk_in);
    while ((sel ? start : dvalid) !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk_in);
      n = n + 1;
    end
    vword = word;
    vstat = dstat;
    if (n >= 200)
      miscompares = miscompares + 1;
  end
  endtask
  task pause;
    repeat (3) @(posedge ref_clk_in);
  endtask
  task crc_pulse;
  begin
    crc_bad <= 1'b1;
    @(posedge ref_clk_in);
    crc_bad <= 1'b0;
  end
  endtask
  task conclude;
  begin
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // ======================================================================
  // Tests
  initial
  begin
    #400000;
    miscompares = miscompares + 1;
    conclude;
  end
  initial
  begin
    repeat (2) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    rdc(`AFM_OFS_IFCFG, 32'hFFFFFFFF, {29'h0, `AFM_RST_IFCFG});
    rdc(`AFM_OFS_CHEN, 32'hFFFFFFFF, {16'h0, `AFM_RST_CHEN});
    wrr(6'h20, 32'hFFFF);
    rdc(6'h20, 32'hFFFFFFFF, 32'h0);
    under <= 1'b1;
    wait_ev(1'b0);
    wait_ev(1'b0);
    chk(vword[31:8], 32'h0);
    chk({vstat, vword[7:0]}, 32'h0);
    rdc(`AFM_OFS_STATUS, 32'h40, 32'h40);
    rdc(`AFM_OFS_RESULT, 32'hFFFFFFFF, 32'h0);
    rdc(`AFM_OFS_STATUS, 32'h40, 32'h40);
    under <= 1'b0;
    over <= 1'b1;
    wait_ev(1'b0);
    wait_ev(1'b0);
    chk(vword[31:8], 32'hFFFFFF);
    over <= 1'b0;
    wait_ev(1'b0);
    rdc(`AFM_OFS_STATUS, 32'h40, 32'h0);
    crc_pulse;
    rdc(`AFM_OFS_STATUS, 32'h20, 32'h20);
    rdc(`AFM_OFS_STATUS, 32'h20, 32'h0);
    wrr(`AFM_OFS_IFCFG, 32'h4);
    wrr(`AFM_OFS_SETUP0, 32'h1234);
    rdc(`AFM_OFS_STATUS, 32'h10, 32'h10);
    wrr(`AFM_OFS_IFCFG, 32'h0);
    rdc(`AFM_OFS_STATUS, 32'h10, 32'h0);
    wrr(`AFM_OFS_IFCFG, 32'h4);
    wrr(`AFM_OFS_IFCFG, 32'h6);
    rdc(`AFM_OFS_STATUS, 32'h10, 32'h0);
    wrr(`AFM_OFS_IFCFG, 32'h2);
    wrr(`AFM_OFS_CHEN, 32'h5);
    wait_ev(1'b0);
    wait_ev(1'b0);
    cv = vword[3:0];
    chk(vstat, 32'h1);
    chk(cv & 4'hD, 32'h0);
    wait_ev(1'b0);
    chk(vword[3:0], cv ^ 4'h2);
    wrr(`AFM_OFS_IOCFG, 32'h7);
    pause;
    chk({fp_oe, pin}, 32'h3);
    wrr(`AFM_OFS_IOCFG, 32'h3);
    pause;
    chk({fp_oe, pin}, 32'h2);
    wrr(`AFM_OFS_IOCFG, 32'h0);
    pause;
    chk(fp_oe, 32'h0);
    wrr(`AFM_OFS_IOCFG, 32'h2);
    pause;
    chk(pin, 32'h1);
    crc_pulse;
    pause;
    chk(pin, 32'h0);
    rdc(`AFM_OFS_STATUS, 32'h20, 32'h20);
    pause;
    chk(pin, 32'h1);
    wrr(`AFM_OFS_IOCFG, 32'h1);
    ext_lvl <= 1'b0;
    pause;
    rdc(`AFM_OFS_IOCFG, 32'h4, 32'h0);
    rdc(`AFM_OFS_STATUS, 32'h40, 32'h40);
    ext_lvl <= 1'b1;
    pause;
    rdc(`AFM_OFS_IOCFG, 32'h4, 32'h4);
    rdc(`AFM_OFS_STATUS, 32'h40, 32'h0);
    slow <= 1'b1;
    wrr(`AFM_OFS_IFCFG, 32'h3);
    wait_ev(1'b1);
    trig_n <= 1'b0;
    wait_ev(1'b0);
    chk(done_n, 32'h0);
    cv = vword[3:0];
    chk(vword[31:8], 32'hAAAAAA);
    rdc(`AFM_OFS_RESULT, 32'hFFFFFFFF, 32'h00AAAAAA);
    pause;
    chk(done_n, 32'h1);
    hits = 0;
    repeat (10)
    begin
      @(posedge ref_clk_in);
      hits = hits + (start === 1'b1);
    end
    chk(hits, 32'h0);
    trig_n <= 1'b1;
    wait_ev(1'b1);
    chk(chan, cv ^ 4'h2);
    conclude;
  end
endmodule // afm_fault_trigger_tb
